/* pll_startup_defs.vh */
`ifndef PLL_STARTUP_DEFS_VH
`define PLL_STARTUP_DEFS_VH

`define ADDR_STARTUP_TIMING_B    8'h11
`define ADDR_SILICON_REVISION    8'h18
`define ADDR_REFERENCE_INPUT_CFG 8'h1A

`define RST_STARTUP_TIMING_B     16'h06C4
`define RST_REFERENCE_INPUT_CFG  16'h0B14

`define REV_RESERVED_HIGH        8'h06

// startup_timing_b fields
`define SW_DLY_MSB               14
`define SW_DLY_LSB               11
`define DET_WAIT_MSB             10
`define DET_WAIT_LSB             8
`define CAP_SETTLE_MSB           7
`define CAP_SETTLE_LSB           6
`define CROSS_STEP_MSB           5
`define CROSS_STEP_LSB           0

// reference_input_config fields
`define REF_INBUF_BIT            15
`define LOAD_CAP_MSB             12
`define LOAD_CAP_LSB             8
`define FINE_TRIM_MSB            7
`define FINE_TRIM_LSB            6
`define XO_GM_MSB                5
`define XO_GM_LSB                2
`define XIN_INBUF_MSB            1
`define XIN_INBUF_LSB            0

// Timing scale factors
`define SW_DLY_SHIFT             6
`define DET_WAIT_BASE_SHIFT      5
`define DET_WAIT_MAX_CODE        3'h3
`define CAP_SETTLE_SHIFT         5
`define CROSS_STEP_SHIFT         2

`define TIMER_WIDTH              16

`endif

/* tick_delay_timer.v */
`timescale 1ns/1ps
`include "pll_startup_defs.vh"

module tick_delay_timer
(
  input  wire                      clk,      // System clock
  input  wire                      reset_n,  // Synchronous reset, active low
  input  wire                      start,    // Load count and begin
  input  wire                      abort,    // Drop a running wait
  input  wire                      tick,     // Period strobe of the counted clock
  input  wire [`TIMER_WIDTH-1:0]   count,    // Periods to wait
  output wire                      busy,     // Waiting
  output reg                       done      // One-cycle pulse at end of wait
);

  reg [`TIMER_WIDTH-1:0] remain_q;
  reg                    busy_q;

  assign busy = busy_q;

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      remain_q <= {`TIMER_WIDTH{1'b0}};
      busy_q   <= 1'b0;
      done     <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (abort)
      begin
        busy_q <= 1'b0;
      end
      else if (start)
      begin
        remain_q <= count;
        busy_q   <= 1'b1;
      end
      else if (busy_q)
      begin
        // Zero count ends on the next cycle with no tick needed
        if (remain_q == {`TIMER_WIDTH{1'b0}})
        begin
          busy_q <= 1'b0;
          done   <= 1'b1;
        end
        else if (tick)
        begin
          remain_q <= remain_q - {{(`TIMER_WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // tick_delay_timer

/* pll_startup_input_config_regs.v */
`timescale 1ns/1ps
`include "pll_startup_defs.vh"

module pll_startup_input_config_regs
#(
  parameter [7:0] REVISION_ID = 8'h5A  // Arbitrary value
)
(
  input  wire        clk,                    // System clock, 100 MHz
  input  wire        reset_n,                // Synchronous reset, active low
  input  wire [7:0]  reg_addr,               // Register address from serial port
  input  wire        reg_wr,                 // Write strobe
  input  wire [15:0] reg_wdata,              // Write data
  input  wire        reg_rd,                 // Read strobe
  output reg  [15:0] reg_rdata,              // Read data, valid cycle after reg_rd
  input  wire        sm_tick,                // State-machine clock period strobe
  input  wire        ref_tick,               // Reference clock period strobe
  input  wire        pfd_tick,               // PFD clock period strobe
  input  wire        any_active,             // Some startup signal still active
  output reg         sm_clock_off,           // Startup state-machine clock gated off
  input  wire        detect_start,           // Begin wait for outputs
  output wire        detect_busy,            // Detect wait running
  output wire        detect_declared,        // Pulse: detect declared
  input  wire        cap_code_applied,       // Pulse: new capacitor code applied
  output wire        cap_settle_busy,        // Settle wait running
  output wire        cap_settle_done,        // Pulse: next cap code may be applied
  input  wire        cross_code_changed,     // Pulse: cross code changed
  output wire        cross_step_busy,        // Cross code wait running
  output wire        cross_step_done,        // Pulse: next cross code may follow
  output reg  [4:0]  crystal_load_cap_sel,   // Crystal load capacitance code
  output reg  [1:0]  crystal_bias_fine_trim, // Crystal bias LSB fine trim
  output reg  [3:0]  crystal_bias_sel,       // Crystal bias current code
  output reg  [1:0]  xin_inbuf_sel,          // Crystal pin input buffer select
  output reg         ref_inbuf_diff          // Reference buffer differential
);

  localparam [2:0] ST_RUN  = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_OFF  = 3'b100;

  reg [15:0] startup_timing_b_q;
  reg [15:0] reference_input_config_q;
  reg [2:0]  state_q;
  reg [2:0]  state_d;
  reg        clk_off_start;

  wire [3:0] switch_wait_code;
  wire [2:0] detect_wait_code;
  wire [1:0] cap_code_settle_wait;
  wire [5:0] cross_code_step_wait;

  wire [3*`TIMER_WIDTH-1:0] timer_count;
  wire [2:0]                timer_start;
  wire [2:0]                timer_tick;
  wire [2:0]                timer_busy;
  wire [2:0]                timer_done;
  wire                      off_busy;
  wire                      off_done;

  function [`TIMER_WIDTH-1:0] detect_cycles;
    input [2:0] code;
    begin
      // Codes above 3 have no defined length, held at the longest wait
      if (code > `DET_WAIT_MAX_CODE)
        detect_cycles = {{(`TIMER_WIDTH-1){1'b0}}, 1'b1}
                        << (`DET_WAIT_BASE_SHIFT + 3);
      else
        detect_cycles = {{(`TIMER_WIDTH-1){1'b0}}, 1'b1}
                        << (`DET_WAIT_BASE_SHIFT + code);
    end
  endfunction

  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  assign switch_wait_code     = startup_timing_b_q[`SW_DLY_MSB:`SW_DLY_LSB];
  assign detect_wait_code     = startup_timing_b_q[`DET_WAIT_MSB:`DET_WAIT_LSB];
  assign cap_code_settle_wait = startup_timing_b_q[`CAP_SETTLE_MSB:`CAP_SETTLE_LSB];
  assign cross_code_step_wait = startup_timing_b_q[`CROSS_STEP_MSB:`CROSS_STEP_LSB];

  // Register writes; revision address has no storage so writes vanish
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      startup_timing_b_q       <= `RST_STARTUP_TIMING_B;
      reference_input_config_q <= `RST_REFERENCE_INPUT_CFG;
    end
    else if (reg_wr)
    begin
      if (hit(reg_addr, `ADDR_STARTUP_TIMING_B))
        startup_timing_b_q <= reg_wdata;
      if (hit(reg_addr, `ADDR_REFERENCE_INPUT_CFG))
        reference_input_config_q <= reg_wdata;
    end
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      reg_rdata <= 16'h0000;
    end
    else if (reg_rd)
    begin
      if (hit(reg_addr, `ADDR_STARTUP_TIMING_B))
        reg_rdata <= startup_timing_b_q;
      else if (hit(reg_addr, `ADDR_SILICON_REVISION))
        reg_rdata <= {`REV_RESERVED_HIGH, REVISION_ID};
      else if (hit(reg_addr, `ADDR_REFERENCE_INPUT_CFG))
        reg_rdata <= reference_input_config_q;
      else
        reg_rdata <= 16'h0000;
    end
  end

  // Analog trims registered so the buffers never see a decode glitch
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      crystal_load_cap_sel   <= 5'h00;
      crystal_bias_fine_trim <= 2'h0;
      crystal_bias_sel       <= 4'h0;
      xin_inbuf_sel          <= 2'h0;
      ref_inbuf_diff         <= 1'b0;
    end
    else
    begin
      crystal_load_cap_sel   <= reference_input_config_q[`LOAD_CAP_MSB:`LOAD_CAP_LSB];
      crystal_bias_fine_trim <= reference_input_config_q[`FINE_TRIM_MSB:`FINE_TRIM_LSB];
      crystal_bias_sel       <= reference_input_config_q[`XO_GM_MSB:`XO_GM_LSB];
      xin_inbuf_sel          <= reference_input_config_q[`XIN_INBUF_MSB:`XIN_INBUF_LSB];
      ref_inbuf_diff         <= reference_input_config_q[`REF_INBUF_BIT];
    end
  end

  assign timer_count[`TIMER_WIDTH-1:0] = detect_cycles(detect_wait_code);
  assign timer_count[2*`TIMER_WIDTH-1:`TIMER_WIDTH] =
    {{(`TIMER_WIDTH-7){1'b0}}, cap_code_settle_wait, 5'h00};
  assign timer_count[3*`TIMER_WIDTH-1:2*`TIMER_WIDTH] =
    {{(`TIMER_WIDTH-8){1'b0}}, cross_code_step_wait, 2'h0};

  assign timer_start = {cross_code_changed, cap_code_applied, detect_start};
  assign timer_tick  = {sm_tick, ref_tick, pfd_tick};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_wait
      tick_delay_timer u_timer
      (
        .clk     (clk),
        .reset_n (reset_n),
        .start   (timer_start[gi]),
        .abort   (1'b0),
        .tick    (timer_tick[gi]),
        .count   (timer_count[(gi+1)*`TIMER_WIDTH-1:gi*`TIMER_WIDTH]),
        .busy    (timer_busy[gi]),
        .done    (timer_done[gi])
      );
    end
  endgenerate

  assign detect_busy     = timer_busy[0];
  assign detect_declared = timer_done[0];
  assign cap_settle_busy = timer_busy[1];
  assign cap_settle_done = timer_done[1];
  assign cross_step_busy = timer_busy[2];
  assign cross_step_done = timer_done[2];

  // Any new activity restarts the switch-off wait from the full count
  always @*
  begin
    state_d       = state_q;
    clk_off_start = 1'b0;
    case (state_q)
      ST_RUN:
      begin
        if (!any_active)
        begin
          state_d       = ST_WAIT;
          clk_off_start = 1'b1;
        end
      end
      ST_WAIT:
      begin
        if (any_active)
          state_d = ST_RUN;
        else if (off_done)
          state_d = ST_OFF;
      end
      ST_OFF:
      begin
        if (any_active)
          state_d = ST_RUN;
      end
      default:
      begin
        state_d = ST_RUN;
      end
    endcase
  end

  tick_delay_timer u_off_timer
  (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (clk_off_start),
    .abort   (any_active),
    .tick    (sm_tick),
    .count   ({{(`TIMER_WIDTH-10){1'b0}}, switch_wait_code, 6'h00}),
    .busy    (off_busy),
    .done    (off_done)
  );

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_q      <= ST_RUN;
      sm_clock_off <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      sm_clock_off <= (state_d == ST_OFF);
    end
  end

endmodule // pll_startup_input_config_regs

/* pll_cfg_props.sv */
`timescale 1ns/1ps
module pll_cfg_props
#(
  parameter [7:0] REVISION_ID = 8'h5A  // Arbitrary value
)
(
  input wire        clk,                    // System clock
  input wire        reset_n,                // Synchronous reset, active low
  input wire [7:0]  reg_addr,               // Register address
  input wire        reg_wr,                 // Write strobe
  input wire [15:0] reg_wdata,              // Write data
  input wire        reg_rd,                 // Read strobe
  input wire [15:0] reg_rdata,              // Read data
  input wire        sm_tick,                // State-machine clock strobe
  input wire        any_active,             // Startup activity
  input wire        sm_clock_off,           // Clock gated off
  input wire        detect_start,           // Detect wait start
  input wire        detect_busy,            // Detect wait running
  input wire        cap_code_applied,       // Settle wait start
  input wire        cap_settle_busy,        // Settle wait running
  input wire        cross_code_changed,     // Cross wait start
  input wire        cross_step_busy,        // Cross wait running
  input wire [4:0]  crystal_load_cap_sel,   // Load capacitance code
  input wire [1:0]  crystal_bias_fine_trim  // Bias fine trim
);
  reg  [15:0] tim_q;
  reg  [11:0] idle_q;
  wire [4:0]  wd_cap = reg_wdata[12:8];
  wire [1:0]  wd_trim = reg_wdata[7:6];

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Lower bound only: ticks in the launch cycle are counted here too
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      tim_q  <= 16'h06C4;
      idle_q <= 12'h000;
    end
    else
    begin
      if (reg_wr && reg_addr == 8'h11)
        tim_q <= reg_wdata;
      idle_q <= any_active ? 12'h000 : idle_q + {11'h000, sm_tick};
    end
  end

  chk_rev_fixed: assert property (reg_rd && reg_addr == 8'h18 |=>
    reg_rdata == {8'h06, REVISION_ID}) else $error("revision read wrong");
  chk_load_cap_copy: assert property (reg_wr && reg_addr == 8'h1A |-> ##2
    crystal_load_cap_sel == $past(wd_cap, 2)) else $error("load cap not applied");
  chk_fine_trim_copy: assert property (reg_wr && reg_addr == 8'h1A |-> ##2
    crystal_bias_fine_trim == $past(wd_trim, 2)) else $error("fine trim not applied");
  chk_clk_off_drop: assert property (any_active |=> !sm_clock_off)
    else $error("clock stays off while active");
  chk_clk_off_wait: assert property ($rose(sm_clock_off) |->
    idle_q >= {2'h0, tim_q[14:11], 6'h00}) else $error("clock off too early");
  chk_detect_start: assert property (detect_start |=> detect_busy)
    else $error("detect wait not started");
  chk_cap_start: assert property (cap_code_applied |=> cap_settle_busy)
    else $error("settle wait not started");
  chk_cross_start: assert property (cross_code_changed |=> cross_step_busy)
    else $error("cross wait not started");
endmodule // pll_cfg_props

bind pll_startup_input_config_regs pll_cfg_props #(.REVISION_ID(REVISION_ID)) i_props (.*);

/* pll_startup_input_config_regs_test.sv */
`timescale 1ns/1ps
module pll_startup_input_config_regs_test;
  reg         clk = 1'b0;
  reg         reset_n = 1'b0;
  reg  [7:0]  reg_addr = 8'h00;
  reg         reg_wr = 1'b0;
  reg  [15:0] reg_wdata = 16'h0000;
  reg         reg_rd = 1'b0;
  reg         act = 1'b1;
  reg  [2:0]  strt = 3'h0;
  reg  [3:0]  tk = 4'h0;
  reg  [15:0] rd_q;
  integer     fail_count = 0;
  integer     checks = 0;
  integer     i;
  integer     v;
  wire [15:0] reg_rdata;
  wire [3:0]  dn;
  wire [4:0]  crystal_load_cap_sel;
  wire [1:0]  crystal_bias_fine_trim;
  wire [3:0]  crystal_bias_sel;
  wire [1:0]  xin_inbuf_sel;
  wire        ref_inbuf_diff;

  always #5 clk = ~clk;

  pll_startup_input_config_regs i_pll_startup_input_config_regs
  (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sm_tick(tk[2] | tk[3]), .ref_tick(tk[1]), .pfd_tick(tk[0]),
    .any_active(act), .sm_clock_off(dn[3]), .detect_start(strt[0]),
    .detect_busy(), .detect_declared(dn[0]), .cap_code_applied(strt[1]),
    .cap_settle_busy(), .cap_settle_done(dn[1]), .cross_code_changed(strt[2]),
    .cross_step_busy(), .cross_step_done(dn[2]),
    .crystal_load_cap_sel(crystal_load_cap_sel),
    .crystal_bias_fine_trim(crystal_bias_fine_trim), .crystal_bias_sel(crystal_bias_sel),
    .xin_inbuf_sel(xin_inbuf_sel), .ref_inbuf_diff(ref_inbuf_diff)
  );

  task chk(input [8*12-1:0] nm, input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp)
      begin
        fail_count = fail_count + 1;
        $display("ERROR %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // Every crystal and buffer output against the fields of one register word
  task outs(input [15:0] r);
    begin
      chk("load cap", {11'h000, crystal_load_cap_sel}, {11'h000, r[12:8]});
      chk("fine trim", {14'h0000, crystal_bias_fine_trim}, {14'h0000, r[7:6]});
      chk("bias sel", {12'h000, crystal_bias_sel}, {12'h000, r[5:2]});
      chk("xin sel", {14'h0000, xin_inbuf_sel}, {14'h0000, r[1:0]});
      chk("ref diff", {15'h0000, ref_inbuf_diff}, {15'h0000, r[15]});
    end
  endtask

  task wr(input [7:0] a, input [15:0] d);
    begin
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      // Idle cycle so a following call never re-raises the strobe at once
      @(posedge clk);
      #1;
    end
  endtask

  task rd(input [7:0] a);
    begin
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      rd_q = reg_rdata;
      @(posedge clk);
      #1;
    end
  endtask

  // Ticks spaced five cycles apart so none lands in the done latency
  task tmr(input integer s, input integer n);
    integer c;
    integer k;
    begin
      c = 0;
      if (s == 3)
        act = 1'b0;
      else
        strt[s] = 1'b1;
      @(posedge clk);
      #1;
      strt = 3'h0;
      for (k = 0; k < 6000 && dn[s] !== 1'b1; k = k + 1)
      begin
        tk[s] = (k % 5 == 2);
        c = c + tk[s];
        @(posedge clk);
        #1;
      end
      tk = 4'h0;
      chk("tick count", c[15:0], n[15:0]);
    end
  endtask

  task results;
    begin
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  initial
  begin
    #300000;
    fail_count = fail_count + 1;
    results;
  end

  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    reset_n = 1'b1;
    rd(8'h11);
    chk("timing rst", rd_q, 16'h06C4);
    rd(8'h1A);
    chk("input rst", rd_q, 16'h0B14);
    outs(16'h0B14);
    rd(8'h18);
    chk("revision", rd_q, {8'h06, 8'h5A});
    wr(8'h18, 16'h0000);
    rd(8'h18);
    chk("revision wr", rd_q, {8'h06, 8'h5A});
    rd(8'h00);
    chk("unmapped", rd_q, 16'h0000);
    $display("test registers done");
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(8'h1A, (i == 0) ? 16'h9FC2 : 16'h0014);
      @(posedge clk);
      #1;
      chk("load cap", {11'h000, crystal_load_cap_sel}, (i == 0) ? 16'h001F : 16'h0000);
      chk("fine trim", {14'h0000, crystal_bias_fine_trim}, (i == 0) ? 16'h0003 : 16'h0000);
      outs((i == 0) ? 16'h9FC2 : 16'h0014);
    end
    $display("test crystal done");
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(8'h11, i[15:0] << 8);
      tmr(0, 32 << i);
    end
    // Codes above 3 are held at the longest wait
    wr(8'h11, 16'h0600);
    tmr(0, 256);
    $display("test detect done");
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(8'h11, i[15:0] << 6);
      tmr(1, 32 * i);
    end
    $display("test settle done");
    for (i = 0; i < 3; i = i + 1)
    begin
      v = (i == 2) ? 63 : i;
      wr(8'h11, v[15:0]);
      tmr(2, 4 * v);
    end
    $display("test cross done");
    wr(8'h11, 16'h1000);
    tmr(3, 128);
    act = 1'b1;
    @(posedge clk);
    #1;
    chk("clock back", {15'h0000, dn[3]}, 16'h0000);
    $display("test clock off done");
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    rd(8'h11);
    chk("timing rst2", rd_q, 16'h06C4);
    rd(8'h1A);
    chk("input rst2", rd_q, 16'h0B14);
    outs(16'h0B14);
    $display("test second reset done");
    results;
  end
endmodule // pll_startup_input_config_regs_test
